// ### hw/tfs_compare.sv
// Range and threshold comparator for the fault status block.
// Assumes temperatures and thresholds held stable by the caller.
`timescale 1ns/1ps
`include "tfs_defs.svh"

module tfs_compare (
  tfs_cmp_if.chk cmp
);
  import tfs_pkg::*;

  // ==========================================================
  // Range limits per type
  logic signed [7:0] cj_min;
  logic signed [11:0] tc_min;
  logic signed [11:0] tc_max;
  logic signed [15:0] cj_min_s;
  logic signed [15:0] cj_max_s;
  logic signed [18:0] tc_min_s;
  logic signed [18:0] tc_max_s;

  always_comb
  begin
    cj_min = `TFS_CJ_MIN_EJKNT;
    tc_min = `TFS_TC_MIN_KNT;
    tc_max = `TFS_TC_MAX_K;
    case (cmp.tc_type)
      `TFS_TYPE_B:
      begin
        cj_min = `TFS_CJ_MIN_B;
        tc_min = `TFS_TC_MIN_B;
        tc_max = `TFS_TC_MAX_B;
      end
      `TFS_TYPE_E:
      begin
        tc_min = `TFS_TC_MIN_E;
        tc_max = `TFS_TC_MAX_E;
      end
      `TFS_TYPE_J:
      begin
        tc_min = `TFS_TC_MIN_J;
        tc_max = `TFS_TC_MAX_J;
      end
      `TFS_TYPE_N: tc_max = `TFS_TC_MAX_N;
      `TFS_TYPE_R, `TFS_TYPE_S:
      begin
        cj_min = `TFS_CJ_MIN_RS;
        tc_min = `TFS_TC_MIN_RS;
        tc_max = `TFS_TC_MAX_RS;
      end
      `TFS_TYPE_T: tc_max = `TFS_TC_MAX_T;
      default: tc_max = `TFS_TC_MAX_K;
    endcase
  end

  // ==========================================================
  // Scale limits to conversion units
  assign cj_min_s = {cj_min, {`TFS_CJ_FRAC_W{1'b0}}};
  assign cj_max_s = {`TFS_CJ_MAX, {`TFS_CJ_FRAC_W{1'b0}}};
  assign tc_min_s = {tc_min, {`TFS_TC_FRAC_W{1'b0}}};
  assign tc_max_s = {tc_max, {`TFS_TC_FRAC_W{1'b0}}};

  // ==========================================================
  // Flag conditions
  assign cmp.cold_junction_out_of_range = (cmp.cj_temp < cj_min_s) || (cmp.cj_temp > cj_max_s);
  assign cmp.hot_junction_out_of_range = !tfs_is_voltage(cmp.tc_type)
    && ((cmp.tc_temp < tc_min_s) || (cmp.tc_temp > tc_max_s));
  assign cmp.cj_high = cmp.cj_temp > $signed({cmp.cj_high_thr, {`TFS_CJ_FRAC_W{1'b0}}});
  assign cmp.cj_low = cmp.cj_temp < $signed({cmp.cj_low_thr, {`TFS_CJ_FRAC_W{1'b0}}});
  assign cmp.tc_high = cmp.tc_temp > $signed({cmp.tc_high_thr, {`TFS_THR_SHIFT{1'b0}}});
  assign cmp.tc_low = cmp.tc_temp < $signed({cmp.tc_low_thr, {`TFS_THR_SHIFT{1'b0}}});
endmodule

// ### hw/tfs_fault_status.sv
// Fault status flags and fault output of a thermocouple converter.
// Assumes conversion results and thresholds from logic on clk,
// and the analog input-voltage and open-circuit detectors on raw pins.
//
// How it works
// - Cold junction outside type range sets bit 7
// - Hot junction outside type range sets bit 6
// - Cold junction strictly above high limit sets bit 5
// - Cold junction strictly below low limit sets bit 4
// - Hot junction strictly above high limit sets bit 3
// - Hot junction strictly below low limit sets bit 2
// - Negative or over-supply input sets bit 1
// - Input fault halts conversions, detection, comparator clearing
// - Open thermocouple sets bit 0
// - Unmasked threshold, voltage, open flags drive fault low
// - Comparator mode flags follow conditions directly
// - Interrupt mode latches flags until clear written
`timescale 1ns/1ps
`include "tfs_defs.svh"

module tfs_fault_status (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire tfs_pkg::tfs_cj_temp_t cj_temp,
  input wire logic cj_valid,
  input wire tfs_pkg::tfs_tc_temp_t tc_temp,
  input wire logic tc_valid,
  input wire tfs_pkg::tfs_cj_thr_t cj_high_thr,
  input wire tfs_pkg::tfs_cj_thr_t cj_low_thr,
  input wire tfs_pkg::tfs_tc_thr_t tc_high_thr,
  input wire tfs_pkg::tfs_tc_thr_t tc_low_thr,
  input wire tfs_pkg::tfs_type_t tc_type,
  input wire logic interrupt_mode,
  input wire logic fault_clear,
  input wire tfs_pkg::tfs_mask_t fault_mask,
  input wire logic input_voltage_fault,
  input wire logic open_circuit,
  input wire logic rd_en,
  input wire logic [`TFS_ADDR_W-1:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic conv_halt,
  output logic fault_n
);
  import tfs_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [`TFS_PIN_N-1:0] pin_raw;
  logic [`TFS_PIN_N-1:0] sync1_reg;
  logic [`TFS_PIN_N-1:0] sync2_reg;
  logic [`TFS_PIN_N-1:0] sync3_reg;
  logic [`TFS_PIN_N-1:0] pin_reg;
  logic [`TFS_PIN_N-1:0] pin_next;

  assign pin_raw = {input_voltage_fault, open_circuit};

  genvar gi;
  generate
    for (gi = 0; gi < `TFS_PIN_N; gi++)
    begin : g_pin
      always_comb
      begin
        pin_next[gi] = pin_reg[gi];
        if (sync2_reg[gi] == sync3_reg[gi])
        begin
          pin_next[gi] = sync3_reg[gi];
        end
      end

      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
          pin_reg[gi] <= 1'b0;
        end
        else if (clk_en)
        begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          pin_reg[gi] <= pin_next[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Filtered pin conditions
  logic input_voltage_fault_cond;
  logic open_cond;

  assign input_voltage_fault_cond = pin_reg[`TFS_PIN_INPUT_VOLTAGE_FAULT];
  assign open_cond = pin_reg[`TFS_PIN_OPEN];

  // ==========================================================
  // Latched conversion results
  tfs_cmp_if cmp ();

  tfs_cj_temp_t cj_temp_reg;
  tfs_cj_temp_t cj_temp_next;
  tfs_tc_temp_t tc_temp_reg;
  tfs_tc_temp_t tc_temp_next;
  logic new_result_reg;
  logic new_result_next;

  always_comb
  begin
    cj_temp_next = cj_temp_reg;
    tc_temp_next = tc_temp_reg;
    new_result_next = 1'b0;
    if (!input_voltage_fault_cond)
    begin
      if (cj_valid)
      begin
        cj_temp_next = cj_temp;
      end
      if (tc_valid)
      begin
        tc_temp_next = tc_temp;
      end
      new_result_next = cj_valid || tc_valid;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cj_temp_reg <= '0;
      tc_temp_reg <= '0;
      new_result_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      cj_temp_reg <= cj_temp_next;
      tc_temp_reg <= tc_temp_next;
      new_result_reg <= new_result_next;
    end
  end

  assign cmp.cj_temp = cj_temp_reg;
  assign cmp.tc_temp = tc_temp_reg;
  assign cmp.cj_high_thr = cj_high_thr;
  assign cmp.cj_low_thr = cj_low_thr;
  assign cmp.tc_high_thr = tc_high_thr;
  assign cmp.tc_low_thr = tc_low_thr;
  assign cmp.tc_type = tc_type;

  tfs_compare u_compare (
    .cmp(cmp.chk)
  );

  // ==========================================================
  // Temperature conditions, refreshed per result
  logic [`TFS_TEMP_FLAG_N-1:0] temp_cond_reg;
  logic [`TFS_TEMP_FLAG_N-1:0] temp_cond_next;

  always_comb
  begin
    temp_cond_next = temp_cond_reg;
    if (new_result_reg && !input_voltage_fault_cond)
    begin
      temp_cond_next = {cmp.cold_junction_out_of_range, cmp.hot_junction_out_of_range, cmp.cj_high, cmp.cj_low,
        cmp.tc_high, cmp.tc_low};
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      temp_cond_reg <= '0;
    end
    else if (clk_en)
    begin
      temp_cond_reg <= temp_cond_next;
    end
  end

  // ==========================================================
  // Fault status register
  tfs_mode_t mode;
  tfs_status_t cond;
  tfs_status_t status_reg;
  tfs_status_t status_next;
  logic fault_n_reg;
  logic fault_n_next;
  logic halt_reg;
  logic halt_next;

  assign mode = interrupt_mode ? TFS_MODE_INTERRUPT : TFS_MODE_COMPARATOR;
  assign cond = {temp_cond_reg, input_voltage_fault_cond, open_cond};

  always_comb
  begin
    status_next = status_reg;
    case (mode)
      TFS_MODE_COMPARATOR:
      begin
        if (input_voltage_fault_cond)
        begin
          status_next[`TFS_BIT_INPUT_VOLTAGE_FAULT] = 1'b1;
        end
        else
        begin
          status_next = cond;
        end
      end
      TFS_MODE_INTERRUPT:
      begin
        if (fault_clear)
        begin
          status_next = `TFS_FAULT_STATUS_RST;
        end
        if (input_voltage_fault_cond)
        begin
          status_next[`TFS_BIT_INPUT_VOLTAGE_FAULT] = 1'b1;
        end
        else
        begin
          status_next = status_next | cond;
        end
      end
      default: status_next = cond;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_reg <= `TFS_FAULT_STATUS_RST;
    end
    else if (clk_en)
    begin
      status_reg <= status_next;
    end
  end

  // ==========================================================
  // Fault output and conversion halt
  always_comb
  begin
    fault_n_next = !(|(status_next[`TFS_BIT_CJ_HIGH:`TFS_BIT_OPEN] & ~fault_mask));
    halt_next = input_voltage_fault_cond;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fault_n_reg <= 1'b1;
      halt_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      fault_n_reg <= fault_n_next;
      halt_reg <= halt_next;
    end
  end

  assign fault_n = fault_n_reg;
  assign conv_halt = halt_reg;

  // ==========================================================
  // Register read port
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;

  always_comb
  begin
    rd_data_next = rd_data_reg;
    rd_valid_next = rd_en;
    if (rd_en)
    begin
      rd_data_next = `TFS_RDATA_IDLE;
      if (rd_addr == `TFS_FAULT_STATUS_ADDR)
      begin
        rd_data_next = status_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_data_reg <= `TFS_RDATA_IDLE;
      rd_valid_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
endmodule

// ### shared/tfs_cmp_if.sv
// Carrier between the status keeper and its comparator.
// Assumes tfs_pkg compiled first.
`timescale 1ns/1ps

interface tfs_cmp_if;
  import tfs_pkg::*;
  tfs_cj_temp_t cj_temp;
  tfs_tc_temp_t tc_temp;
  tfs_cj_thr_t cj_high_thr;
  tfs_cj_thr_t cj_low_thr;
  tfs_tc_thr_t tc_high_thr;
  tfs_tc_thr_t tc_low_thr;
  tfs_type_t tc_type;
  logic cold_junction_out_of_range;
  logic hot_junction_out_of_range;
  logic cj_high;
  logic cj_low;
  logic tc_high;
  logic tc_low;

  modport src (
    output cj_temp, tc_temp, cj_high_thr, cj_low_thr, tc_high_thr, tc_low_thr, tc_type,
    input cold_junction_out_of_range, hot_junction_out_of_range, cj_high, cj_low, tc_high, tc_low
  );
  modport chk (
    input cj_temp, tc_temp, cj_high_thr, cj_low_thr, tc_high_thr, tc_low_thr, tc_type,
    output cold_junction_out_of_range, hot_junction_out_of_range, cj_high, cj_low, tc_high, tc_low
  );
endinterface

// ### shared/tfs_defs.svh
// Constants for the thermocouple fault status block.
// Assumes inclusion by bare name from package and design files.
`ifndef TFS_DEFS_SVH
`define TFS_DEFS_SVH

// ==========================================================
// Register map
`define TFS_ADDR_W 7
`define TFS_FAULT_STATUS_ADDR 7'h0F
`define TFS_FAULT_STATUS_RST 8'h00
`define TFS_RDATA_IDLE 8'h00

// ==========================================================
// Fault status bit positions
`define TFS_BIT_COLD_JUNCTION_OUT_OF_RANGE 7
`define TFS_BIT_HOT_JUNCTION_OUT_OF_RANGE 6
`define TFS_BIT_CJ_HIGH 5
`define TFS_BIT_CJ_LOW 4
`define TFS_BIT_TC_HIGH 3
`define TFS_BIT_TC_LOW 2
`define TFS_BIT_INPUT_VOLTAGE_FAULT 1
`define TFS_BIT_OPEN 0
`define TFS_MASK_W 6
`define TFS_PIN_N 2
`define TFS_PIN_INPUT_VOLTAGE_FAULT 1
`define TFS_PIN_OPEN 0
`define TFS_TEMP_FLAG_N 6

// ==========================================================
// Thermocouple type codes, bit 3 set selects voltage mode
`define TFS_TYPE_B 4'h0
`define TFS_TYPE_E 4'h1
`define TFS_TYPE_J 4'h2
`define TFS_TYPE_K 4'h3
`define TFS_TYPE_N 4'h4
`define TFS_TYPE_R 4'h5
`define TFS_TYPE_S 4'h6
`define TFS_TYPE_T 4'h7
`define TFS_TYPE_VOLT_BIT 3

// ==========================================================
// Cold-junction range limits, whole degrees
`define TFS_CJ_MIN_EJKNT 8'hC9
`define TFS_CJ_MIN_RS 8'hCE
`define TFS_CJ_MIN_B 8'h00
`define TFS_CJ_MAX 8'h7D

// ==========================================================
// Hot-junction range limits, whole degrees
`define TFS_TC_MIN_B 12'h0FA
`define TFS_TC_MAX_B 12'h71C
`define TFS_TC_MIN_E 12'hF38
`define TFS_TC_MAX_E 12'h3E8
`define TFS_TC_MIN_J 12'hF2E
`define TFS_TC_MAX_J 12'h4B0
`define TFS_TC_MIN_KNT 12'hF38
`define TFS_TC_MAX_K 12'h55C
`define TFS_TC_MAX_N 12'h514
`define TFS_TC_MIN_RS 12'hFCE
`define TFS_TC_MAX_RS 12'h6E8
`define TFS_TC_MAX_T 12'h190

// ==========================================================
// Fraction bits of results, and left shift that aligns hot-junction thresholds
`define TFS_CJ_FRAC_W 8
`define TFS_TC_FRAC_W 7
`define TFS_THR_SHIFT 3

`endif

// ### shared/tfs_pkg.sv
// Types shared by the fault status block.
// Assumes tfs_defs.svh on the include path.
`include "tfs_defs.svh"

package tfs_pkg;
  typedef logic signed [15:0] tfs_cj_temp_t;
  typedef logic signed [18:0] tfs_tc_temp_t;
  typedef logic signed [7:0] tfs_cj_thr_t;
  typedef logic signed [15:0] tfs_tc_thr_t;
  typedef logic [3:0] tfs_type_t;
  typedef logic [7:0] tfs_status_t;
  typedef logic [`TFS_MASK_W-1:0] tfs_mask_t;
  typedef enum logic {TFS_MODE_COMPARATOR, TFS_MODE_INTERRUPT} tfs_mode_t;

  // Voltage mode has no linearization
  function automatic logic tfs_is_voltage(input tfs_type_t t);
    return t[`TFS_TYPE_VOLT_BIT];
  endfunction
endpackage

// ### verif/tb_top.sv
// Self-checking bench for the fault status block.
// Assumes package, host model and checker compiled first.
`timescale 1ns/1ps
`include "tfs_defs.svh"

module tb_top;
  import tfs_pkg::*;
  logic clk = 0, reset_n = 0, cj_valid = 0, tc_valid = 0, interrupt_mode = 0, fault_clear = 0;
  logic input_voltage_fault = 0, open_circuit = 0, rd_en, rd_valid, conv_halt, fault_n;
  logic [`TFS_ADDR_W-1:0] rd_addr;
  logic [`TFS_ADDR_W-1:0] sa = `TFS_FAULT_STATUS_ADDR;
  logic [7:0] rd_data, care;
  tfs_cj_temp_t cj_temp = '0;
  tfs_tc_temp_t tc_temp = '0;
  tfs_cj_thr_t cj_high_thr = '0, cj_low_thr = '0;
  tfs_tc_thr_t tc_high_thr = '0, tc_low_thr = '0;
  tfs_type_t tc_type = '0;
  tfs_mask_t fault_mask = '0;
  logic [31:0] seed = 32'hDCCB05EA, r, q;
  int err_count = 0, n_compared = 0;
  int tlo[8] = '{250, -200, -210, -200, -200, -50, -50, -200};
  int thi[8] = '{1820, 1000, 1200, 1372, 1300, 1768, 1768, 400};

  always #5 clk = ~clk;

  tfs_fault_status uut (.clk, .reset_n, .clk_en(1'b1), .cj_temp, .cj_valid, .tc_temp,
    .tc_valid, .cj_high_thr, .cj_low_thr, .tc_high_thr, .tc_low_thr, .tc_type,
    .interrupt_mode, .fault_clear, .fault_mask, .input_voltage_fault, .open_circuit,
    .rd_en, .rd_addr, .rd_data, .rd_valid, .conv_halt, .fault_n);
  tfs_host host (.clk, .tc_type, .rd_data, .rd_valid, .rd_en, .rd_addr);

  // ==========
  // Helpers
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] model();
    int cj = cj_temp;
    int tc = tc_temp;
    int cmin = (tc_type == 0) ? 0 : (tc_type inside {5, 6}) ? -50 : -55;
    logic [7:0] s;
    s[7] = cj < cmin * 256 || cj > 125 * 256;
    s[6] = !tc_type[3] && (tc < tlo[tc_type[2:0]] * 128 || tc > thi[tc_type[2:0]] * 128);
    s[5] = cj > cj_high_thr * 256;
    s[4] = cj < cj_low_thr * 256;
    s[3] = tc > tc_high_thr * 8;
    s[2] = tc < tc_low_thr * 8;
    s[1] = input_voltage_fault;
    s[0] = open_circuit;
    return s;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic results();
    cj_valid = 1;
    tick(1);
    cj_valid = 0;
    tc_valid = 1;
    tick(1);
    tc_valid = 0;
    tick(8);
  endtask
  task automatic clear();
    fault_clear = 1;
    tick(1);
    fault_clear = 0;
    tick(3);
  endtask
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [`TFS_ADDR_W-1:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] d;
    logic ok;
    host.read(a, d, ok);
    n_compared++;
    if (ok !== 1'b1 || (d & m) !== (e & m) || conv_halt !== input_voltage_fault
        || fault_n !== !(|(e[5:0] & ~fault_mask)))
    begin
      err_count++;
      $display("MISMATCH %0t read %h expected %h fault_n %b", $time, d, e, fault_n);
      if (ok !== 1'b1)
        close_out();
    end
  endtask

  // ==========
  // Sequence
  initial
  begin
    tick(16);
    reset_n = 1;
    tick(2);
    check(sa, 8'h00, 8'hFF);
    check(7'h10, 8'h00, 8'hFF);
    $display("reset test done");
    repeat (40)
    begin
      r = rnd();
      q = rnd();
      tc_type = r[3:0];
      fault_mask = r[9:4];
      cj_high_thr = r[17:10];
      cj_low_thr = r[25:18];
      tc_high_thr = q[15:0];
      tc_low_thr = q[31:16];
      q = rnd();
      cj_temp = r[26] ? {cj_high_thr, 8'h00} : q[15:0];
      tc_temp = r[27] ? {tc_low_thr, 3'b000} : q[31:13];
      care = tc_type[3] ? 8'h7F : 8'hFF;
      results();
      check(sa, model(), care);
    end
    $display("random test done");
    tc_type = 4'h3;
    fault_mask = '0;
    cj_high_thr = 8'h7F;
    cj_low_thr = 8'h80;
    tc_high_thr = 16'h0000;
    tc_low_thr = 16'h8000;
    cj_temp = 16'h1900;
    tc_temp = '0;
    results();
    check(sa, 8'h00, 8'hFF);
    input_voltage_fault = 1;
    tick(10);
    check(sa, 8'h02, 8'hFF);
    tc_temp = 19'h03200;
    results();
    check(sa, 8'h02, 8'hFF);
    input_voltage_fault = 0;
    tick(10);
    check(sa, 8'h00, 8'hFF);
    results();
    check(sa, 8'h08, 8'hFF);
    $display("input fault test done");
    open_circuit = 1;
    tick(10);
    check(sa, 8'h09, 8'hFF);
    fault_mask = 6'h3F;
    tick(3);
    check(sa, 8'h09, 8'hFF);
    fault_mask = '0;
    interrupt_mode = 1;
    open_circuit = 0;
    tc_temp = '0;
    results();
    check(sa, 8'h09, 8'hFF);
    clear();
    check(sa, 8'h00, 8'hFF);
    open_circuit = 1;
    tick(10);
    clear();
    check(sa, 8'h01, 8'hFF);
    $display("interrupt test done");
    open_circuit = 0;
    reset_n = 0;
    tick(2);
    reset_n = 1;
    tick(2);
    check(sa, 8'h00, 8'hFF);
    $display("second reset test done");
    close_out();
  end
endmodule

// ### verif/tfs_fault_status_sva.sv
// Checker for the fault status block ports.
// Assumes clk_en held high by the bench.
`timescale 1ns/1ps
`include "tfs_defs.svh"

module tfs_fault_status_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire tfs_pkg::tfs_cj_temp_t cj_temp,
  input wire logic cj_valid,
  input wire tfs_pkg::tfs_tc_temp_t tc_temp,
  input wire logic tc_valid,
  input wire tfs_pkg::tfs_cj_thr_t cj_low_thr,
  input wire tfs_pkg::tfs_tc_thr_t tc_high_thr,
  input wire tfs_pkg::tfs_mask_t fault_mask,
  input wire logic input_voltage_fault,
  input wire logic open_circuit,
  input wire logic rd_en,
  input wire logic [`TFS_ADDR_W-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic conv_halt,
  input wire logic fault_n
);
  import tfs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========
  // Properties
  property p_rd; rd_en && clk_en |=> rd_valid; endproperty
  property p_unmap; rd_en && rd_addr != `TFS_FAULT_STATUS_ADDR |=> rd_data == 8'h00; endproperty
  property p_halt; input_voltage_fault [*8] |-> conv_halt; endproperty
  property p_input_voltage_fault; (input_voltage_fault && !fault_mask[1]) [*8] |-> !fault_n; endproperty
  property p_open;
    (open_circuit && !input_voltage_fault && !fault_mask[0]) [*8] |-> !fault_n;
  endproperty
  property p_mask; (fault_mask == 6'h3F) [*3] |-> fault_n; endproperty
  property p_tch;
    tc_valid && !conv_halt && !fault_mask[3] && tc_temp > $signed({tc_high_thr, 3'b000})
      |-> ##[3:4] !fault_n;
  endproperty
  property p_cjl;
    cj_valid && !conv_halt && !fault_mask[4] && cj_temp < $signed({cj_low_thr, 8'h00})
      |-> ##[3:4] !fault_n;
  endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_halt: assert property (p_halt) else $error("no halt on input fault");
  a_input_voltage_fault: assert property (p_input_voltage_fault) else $error("input fault not flagged");
  a_open: assert property (p_open) else $error("open circuit not flagged");
  a_mask: assert property (p_mask) else $error("masked fault drives output");
  a_tch: assert property (p_tch) else $error("hot high not flagged");
  a_cjl: assert property (p_cjl) else $error("cold low not flagged");
  c_read: cover property (rd_valid && rd_data != 8'h00);
  c_halt: cover property ($rose(conv_halt));
  c_fault: cover property ($fell(fault_n));
endmodule

bind tfs_fault_status tfs_fault_status_sva chk (.clk, .reset_n, .clk_en, .cj_temp, .cj_valid,
  .tc_temp, .tc_valid, .cj_low_thr, .tc_high_thr, .fault_mask, .input_voltage_fault,
  .open_circuit, .rd_en, .rd_addr, .rd_data, .rd_valid, .conv_halt, .fault_n);

// ### verif/tfs_host.sv
// Host model reading the fault status byte.
// Assumes reads issued by the bench after reset.
`timescale 1ns/1ps
`include "tfs_defs.svh"

module tfs_host (
  input wire logic clk,
  input wire tfs_pkg::tfs_type_t tc_type,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output logic rd_en,
  output logic [`TFS_ADDR_W-1:0] rd_addr
);
  import tfs_pkg::*;
  initial
  begin
    rd_en = 0;
    rd_addr = '0;
  end
  task automatic read(input logic [`TFS_ADDR_W-1:0] a, output logic [7:0] d, output logic ok);
    ok = 0;
    d = 8'h00;
    rd_en = 1;
    rd_addr = a;
    @(posedge clk);
    #1;
    rd_en = 0;
    for (int k = 0; k < 4 && !ok; k++)
    begin
      if (rd_valid === 1'b1)
      begin
        ok = 1;
        d = rd_data;
      end
      else
      begin
        @(posedge clk);
        #1;
      end
    end
    if (tfs_is_voltage(tc_type))
      d[6] = 1'b0;
    @(posedge clk);
    #1;
  endtask
endmodule
